// [design/spf_pkg.sv]
// package: spi flag/data unit constants, state and pin carriers
`default_nettype none
package spf_pkg;
  localparam int          CLK_MHZ     = 50;
  localparam int          SCK_PER_NS  = 160;
  localparam int          HALF_CYC    = SCK_PER_NS * CLK_MHZ / 2000;
  localparam logic [2:0]  HALF_LAST   = 3'(HALF_CYC - 1);
  localparam logic [2:0]  OFF_CTRL    = 3'h0;
  localparam logic [2:0]  OFF_FLAG    = 3'h3;
  localparam logic [2:0]  OFF_DATA    = 3'h4;
  localparam int          CTRL_BUF    = 7;
  localparam int          CTRL_MASTER = 5;
  localparam int          CTRL_SSD    = 2;
  localparam int          CTRL_EN     = 0;
  localparam logic [7:0]  CTRL_MASK   = 8'hA5;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam int          FLG_RXC     = 7;
  localparam int          FLG_TXC     = 6;
  localparam int          FLG_DRE     = 5;
  localparam int          FLG_SSI     = 4;
  localparam int          FLG_OVF     = 0;
  localparam logic [3:0]  BIT_ALL     = 4'h8;
  localparam int          PIN_SCK     = 0;
  localparam int          PIN_MOSI    = 1;
  localparam int          PIN_MISO    = 2;
  localparam int          PIN_SS      = 3;
  // synchronisers start at pin idle: select high, clock low
  localparam logic [3:0]  PIN_RST     = 4'hE;

  typedef enum logic [1:0] {
    SPF_IDLE  = 2'b01,
    SPF_SHIFT = 2'b10
  } spf_st_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spf_pin_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spf_pin_out_t;

  typedef struct packed {
    spf_st_t      st;
    logic [7:0]   ctrl;
    logic [7:0]   shreg;
    logic [3:0]   bitcnt;
    logic [2:0]   div;
    logic [7:0]   txbuf;
    logic         txfull;
    logic [7:0]   rxa;
    logic [7:0]   rxb;
    logic         rxa_v;
    logic         rxb_v;
    logic         rxc;
    logic         txc;
    logic         dre;
    logic         ssi;
    logic         ovf;
    logic         ovf_pend;
    logic         xif;
    logic         wcol;
    logic         arm;
    logic [3:0]   s1;
    logic [3:0]   s2;
    logic [3:0]   s3;
    logic [3:0]   f;
    spf_pin_out_t po;
    logic [7:0]   rdata;
    logic         busy;
  } spf_state_t;
endpackage
`default_nettype wire

// [design/spf_spi_flags.sv]
// module: spi status flags, data register, tx/rx buffers and shifter
//
// Summary of operation
// R1 - buffered: set transfer done when shifter empties and no byte waits; w1c
// R2 - unbuffered: set write collision on data write while a byte is mid-shift
// R3 - collision clears by flag read while set, then any data access
// R4 - buffered: empty flag high when tx buffer empty, low while it holds
// R5 - empty flag reads zero after reset
// R6 - any data write clears the empty flag; one in the cycle a buffered byte completes leaves it set
// R7 - software must refill data or mask the empty interrupt
// R8 - buffered: set select trigger when master is forced to slave by select
// R9 - select trigger never set with select disable; write one clears it
// R10 - unbuffered: empty, select trigger and overflow read as zero
// R11 - buffered: overflow when both rx entries full and third byte arrives
// R12 - with no tx byte pending, overflow waits until next transfer starts
// R13 - overflow holds until software reads the data register
// R14 - software writes zero to the overflow bit position
// R15 - data write starts a transfer shifting the byte out msb first
// R16 - buffered read returns second rx entry, first moves into second
// R17 - buffered mode has two rx stages, one tx stage, split done flags
// R18 - buffered: receive done high while rx data unread; w1c or empty
// R19 - unbuffered: transfer flag on byte done; clear by vector or read pair
// R20 - flag bit six is transfer done when buffered, else write collision
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module spf_spi_flags (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic [2:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic [7:0]                rdata,
  input  wire logic                 vector_ack,
  input  wire spf_pkg::spf_pin_in_t pin_in,
  output spf_pkg::spf_pin_out_t     pin_out,
  output logic                      busy
);
  spf_pkg::spf_state_t q_reg;
  spf_pkg::spf_state_t q_next;

  logic [3:0] fn;
  logic       rise;
  logic       fall;
  logic       buf_on;
  logic       master;
  logic       en;
  logic       done;
  logic       start;
  logic       wr_data;
  logic       rd_data;
  logic       wr_flag;
  logic       rd_flag;
  logic       wr_ctrl;
  logic       sel_fault;
  logic [7:0] rx_byte;
  logic [7:0] flag_view;

  assign rdata   = q_reg.rdata;
  assign pin_out = q_reg.po;
  assign busy    = q_reg.busy;

  // filtered view only moves when the two later stages agree
  for (genvar i = 0; i < 4; i++) begin : g_filt
    assign fn[i] = (q_reg.s2[i] == q_reg.s3[i]) ? q_reg.s3[i] : q_reg.f[i];
  end

  always_comb begin
    q_next   = q_reg;
    buf_on   = q_reg.ctrl[spf_pkg::CTRL_BUF];
    master   = q_reg.ctrl[spf_pkg::CTRL_MASTER];
    en       = q_reg.ctrl[spf_pkg::CTRL_EN];
    wr_data  = wr && (addr == spf_pkg::OFF_DATA);
    rd_data  = rd && (addr == spf_pkg::OFF_DATA);
    wr_flag  = wr && (addr == spf_pkg::OFF_FLAG);
    rd_flag  = rd && (addr == spf_pkg::OFF_FLAG);
    wr_ctrl  = wr && (addr == spf_pkg::OFF_CTRL);
    // a master whose select is pulled low gives up the bus
    sel_fault = en && master && !fn[spf_pkg::PIN_SS]
                && !q_reg.ctrl[spf_pkg::CTRL_SSD];                // R9
    done     = 1'b0;
    start    = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    rx_byte  = q_reg.shreg;

    q_next.s1 = {pin_in.ss_n, pin_in.miso, pin_in.mosi, pin_in.sck};
    q_next.s2 = q_reg.s1;
    q_next.s3 = q_reg.s2;
    q_next.f  = fn;

    flag_view = 8'h00;
    flag_view[spf_pkg::FLG_RXC] = buf_on ? q_reg.rxc : q_reg.xif;
    flag_view[spf_pkg::FLG_TXC] = buf_on ? q_reg.txc : q_reg.wcol; // R20
    flag_view[spf_pkg::FLG_DRE] = buf_on & q_reg.dre;              // R10
    flag_view[spf_pkg::FLG_SSI] = buf_on & q_reg.ssi;              // R10
    flag_view[spf_pkg::FLG_OVF] = buf_on & q_reg.ovf;              // R10

    // software side: clears first so that hardware sets below win
    if (wr_ctrl) begin
      q_next.ctrl = wdata & spf_pkg::CTRL_MASK;
    end
    if (wr_flag && buf_on) begin
      if (wdata[spf_pkg::FLG_RXC]) begin
        q_next.rxc = 1'b0;                                        // R18
      end
      if (wdata[spf_pkg::FLG_TXC]) begin
        q_next.txc = 1'b0;                                        // R1
      end
      if (wdata[spf_pkg::FLG_SSI]) begin
        q_next.ssi = 1'b0;                                        // R9
      end
    end
    if (vector_ack) begin
      q_next.xif = 1'b0;                                          // R19
    end
    if (rd_flag) begin
      q_next.arm = !buf_on && (q_reg.xif || q_reg.wcol);          // R3
    end
    if ((wr_data || rd_data) && q_reg.arm) begin
      q_next.arm  = 1'b0;
      q_next.xif  = 1'b0;                                         // R19
      q_next.wcol = 1'b0;                                         // R3
    end

    // read data, registered so it stands one cycle after the strobe
    q_next.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        spf_pkg::OFF_CTRL: q_next.rdata = q_reg.ctrl;
        spf_pkg::OFF_FLAG: q_next.rdata = flag_view;
        spf_pkg::OFF_DATA: q_next.rdata = q_reg.rxb;
        default:           q_next.rdata = 8'h00;
      endcase
    end
    if (rd_data && buf_on) begin
      q_next.rxb   = q_reg.rxa;                                   // R16
      q_next.rxb_v = q_reg.rxa_v;
      q_next.rxa_v = 1'b0;
      q_next.ovf   = 1'b0;                                        // R13
      if (!q_reg.rxa_v) begin
        q_next.rxc = 1'b0;                                        // R18
      end
    end

    // data write: tx buffer when buffered, else straight to shifter unless mid-shift
    if (wr_data) begin
      q_next.dre = 1'b0;                                          // R6
      if (buf_on) begin
        q_next.txbuf  = wdata;                                    // R17
        q_next.txfull = 1'b1;                                     // R4
      end else if (q_reg.st == spf_pkg::SPF_SHIFT) begin
        q_next.wcol = 1'b1;                                       // R2
      end else begin
        q_next.shreg     = wdata;                                 // R15
        q_next.po.mosi_o = wdata[7];
        q_next.po.miso_o = wdata[7];
        start            = master && en;
      end
    end

    // select pulled low while master: fall back to slave operation
    if (sel_fault) begin                                          // R9
      q_next.ctrl[spf_pkg::CTRL_MASTER] = 1'b0;
      q_next.st       = spf_pkg::SPF_IDLE;
      q_next.po.sck_o = 1'b0;
      if (buf_on) begin
        q_next.ssi = 1'b1;                                        // R8
      end else begin
        q_next.xif = 1'b1;
      end
    end else begin
      unique case (q_reg.st)
        spf_pkg::SPF_IDLE: begin
          q_next.bitcnt = 4'h0;
          q_next.div    = 3'h0;
          if (buf_on && q_reg.txfull && en
              && (master || !fn[spf_pkg::PIN_SS])) begin
            // tx stage hands its byte over as soon as the shifter is free
            q_next.shreg     = q_reg.txbuf;
            q_next.po.mosi_o = q_reg.txbuf[7];
            q_next.po.miso_o = q_reg.txbuf[7];
            q_next.txfull    = wr_data;
            q_next.dre       = !wr_data;                          // R4
            start            = 1'b1;
          end else if (!master && en && !fn[spf_pkg::PIN_SS]) begin
            // a selected slave clocks in even with nothing queued to send
            start = 1'b1;
          end
        end
        spf_pkg::SPF_SHIFT: begin
          if (master) begin
            if (q_reg.div == spf_pkg::HALF_LAST) begin
              q_next.div      = 3'h0;
              q_next.po.sck_o = !q_reg.po.sck_o;
              rise            = !q_reg.po.sck_o;
              fall            = q_reg.po.sck_o;
            end else begin
              q_next.div = q_reg.div + 3'h1;
            end
          end else if (fn[spf_pkg::PIN_SS]) begin
            // slave frame cut short: the partial byte is dropped
            q_next.st = spf_pkg::SPF_IDLE;
          end else begin
            rise = fn[spf_pkg::PIN_SCK] && !q_reg.f[spf_pkg::PIN_SCK];
            fall = !fn[spf_pkg::PIN_SCK] && q_reg.f[spf_pkg::PIN_SCK];
          end
          // sample this cycle's filtered pin: the stored copy lags a clock,
          // which at four clocks a half period takes the previous bit
          if (rise) begin
            q_next.shreg  = {q_reg.shreg[6:0],
                             master ? fn[spf_pkg::PIN_MISO]
                                    : fn[spf_pkg::PIN_MOSI]};
            q_next.bitcnt = q_reg.bitcnt + 4'h1;
          end
          if (fall) begin
            if (q_reg.bitcnt == spf_pkg::BIT_ALL) begin
              done          = 1'b1;
              q_next.bitcnt = 4'h0;
            end else begin
              q_next.po.mosi_o = q_reg.shreg[7];
              q_next.po.miso_o = q_reg.shreg[7];
            end
          end
        end
        default: q_next.st = spf_pkg::SPF_IDLE;
      endcase
    end

    if (done) begin
      rx_byte = q_reg.shreg;
      if (buf_on) begin
        if (!q_next.rxb_v) begin
          q_next.rxb   = rx_byte;
          q_next.rxb_v = 1'b1;
        end else if (!q_next.rxa_v) begin
          q_next.rxa   = rx_byte;
          q_next.rxa_v = 1'b1;
        end else if (q_next.txfull) begin
          q_next.ovf = 1'b1;                                      // R11
        end else begin
          q_next.ovf_pend = 1'b1;                                 // R12
        end
        q_next.rxc = 1'b1;                                        // R18
        if (q_next.txfull) begin
          q_next.shreg     = q_next.txbuf;
          q_next.po.mosi_o = q_next.txbuf[7];
          q_next.po.miso_o = q_next.txbuf[7];
          q_next.txfull    = 1'b0;
          q_next.dre       = 1'b1;                                // R4
          start            = 1'b1;
        end else begin
          q_next.txc = 1'b1;                                      // R1
          q_next.st  = spf_pkg::SPF_IDLE;
        end
      end else begin
        q_next.rxb = rx_byte;
        q_next.xif = 1'b1;                                        // R19
        q_next.st  = spf_pkg::SPF_IDLE;
      end
    end

    if (start) begin
      q_next.st     = spf_pkg::SPF_SHIFT;
      q_next.bitcnt = 4'h0;
      q_next.div    = 3'h0;
      if (q_next.ovf_pend && buf_on) begin
        q_next.ovf      = 1'b1;                                   // R12
        q_next.ovf_pend = 1'b0;
      end
    end

    if (!en) begin
      q_next.st       = spf_pkg::SPF_IDLE;
      q_next.po.sck_o = 1'b0;
    end

    q_next.busy = (q_next.st == spf_pkg::SPF_SHIFT);

    // drive directions follow the role; slave answers only when selected
    q_next.po.sck_oe  = en && q_next.ctrl[spf_pkg::CTRL_MASTER];
    q_next.po.mosi_oe = en && q_next.ctrl[spf_pkg::CTRL_MASTER];
    q_next.po.miso_oe = en && !q_next.ctrl[spf_pkg::CTRL_MASTER]
                        && !fn[spf_pkg::PIN_SS];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q_reg          <= '0;
      q_reg.st       <= spf_pkg::SPF_IDLE;
      q_reg.ctrl     <= spf_pkg::CTRL_RST;
      q_reg.dre      <= 1'b0;                                     // R5
      q_reg.s1       <= spf_pkg::PIN_RST;
      q_reg.s2       <= spf_pkg::PIN_RST;
      q_reg.s3       <= spf_pkg::PIN_RST;
      q_reg.f        <= spf_pkg::PIN_RST;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule
`default_nettype wire

// [testbench/spf_spi_flags_properties.sv]
// checker: port-level properties of the spi flag and data unit
`timescale 1ns/1ps
`default_nettype none
module spf_spi_flags_properties (
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire logic [2:0]            addr,
  input wire logic [7:0]            wdata,
  input wire logic                  wr,
  input wire logic                  rd,
  input wire logic [7:0]            rdata,
  input wire logic                  vector_ack,
  input wire spf_pkg::spf_pin_in_t  pin_in,
  input wire spf_pkg::spf_pin_out_t pin_out,
  input wire logic                  busy
);
  logic [7:0] ctrl_q;
  logic       wrote_q;
  logic       sck_q;
  logic [2:0] rise_n;
  logic       rd_map;
  logic       is_flag;
  assign is_flag = rd && addr == spf_pkg::OFF_FLAG;
  assign rd_map = is_flag || (rd && addr == spf_pkg::OFF_CTRL)
                  || (rd && addr == spf_pkg::OFF_DATA);
  // mirrors software ctrl writes only; a select fault is not seen here
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q  <= 8'h00;
      wrote_q <= 1'h0;
      sck_q   <= 1'h0;
      rise_n  <= 3'h0;
    end else begin
      if (wr && addr == spf_pkg::OFF_CTRL) begin
        ctrl_q <= wdata;
      end
      if (wr && addr == spf_pkg::OFF_DATA) begin
        wrote_q <= 1'h1;
      end
      sck_q <= pin_out.sck_o;
      if (pin_out.sck_o && !sck_q) begin
        rise_n <= rise_n + 3'h1;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_rdata_idle: assert property (!rd_map |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_flag_gap: assert property (is_flag |=> rdata[3:1] == 3'h0)
    else $error("unused flag bits read nonzero");
  chk_unbuf_zero: assert property (is_flag && !ctrl_q[7]
    |=> {rdata[5], rdata[4], rdata[0]} == 3'h0)
    else $error("buffer-only flags set while unbuffered");
  chk_empty_reset: assert property (is_flag && !wrote_q |=> !rdata[5])
    else $error("empty flag set before any data write");
  chk_tx_start: assert property (wr && addr == spf_pkg::OFF_DATA
    && !busy && ctrl_q[0] && ctrl_q[5] |-> ##[1:2] busy)
    else $error("data write did not start a transfer");
  chk_sck_idle: assert property (!busy |-> !pin_out.sck_o)
    else $error("serial clock high outside a transfer");
  chk_mosi_hold: assert property (pin_out.sck_o |-> $stable(pin_out.mosi_o))
    else $error("output data moved while serial clock high");
  chk_byte_bits: assert property ($fell(busy) |-> rise_n == 3'h0)
    else $error("transfer ended off a byte boundary");
endmodule
bind spf_spi_flags spf_spi_flags_properties spf_spi_flags_properties_i (
  .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .vector_ack(vector_ack), .pin_in(pin_in),
  .pin_out(pin_out), .busy(busy));
`default_nettype wire

// [testbench/spf_slave_model.sv]
// model: external spi slave, mode 0, msb first, replies 0xA0 plus count
`timescale 1ns/1ps
`default_nettype none
module spf_slave_model (
  input  wire logic   sck,
  input  wire logic   mosi,
  input  wire logic   sel_n,
  output logic        miso,
  output logic [15:0] rx_hist
);
  logic [7:0] rx_sh = 8'h00;
  logic [7:0] tx_sh = 8'hA0;
  logic [2:0] cnt = 3'h0;
  logic [3:0] num = 4'h0;
  initial rx_hist = 16'h0000;
  // deselected line shows the inverse so stale data cannot pass
  assign miso = sel_n ? ~tx_sh[7] : tx_sh[7];
  always @(posedge sck) begin
    rx_sh <= {rx_sh[6:0], mosi};
    cnt <= cnt + 3'h1;
    if (cnt == 3'h7) begin
      rx_hist <= {rx_hist[7:0], rx_sh[6:0], mosi};
      num <= num + 4'h1;
    end
  end
  always @(negedge sck) begin
    tx_sh <= (cnt == 3'h0) ? {4'hA, num} : {tx_sh[6:0], 1'h0};
  end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// testbench: register-level tests of the spi flag and data unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  clock;
  logic                  reset_n;
  logic [2:0]            addr;
  logic [7:0]            wdata;
  logic                  wr;
  logic                  rd;
  logic [7:0]            rdata;
  logic                  vector_ack;
  logic                  ss_n;
  logic                  sel_n;
  logic                  miso;
  logic                  busy;
  logic [15:0]           rx_hist;
  logic [7:0]            v;
  int                    fails = 0;
  int                    num_checks = 0;
  int                    cyc = 0;
  spf_pkg::spf_pin_in_t  pin_in;
  spf_pkg::spf_pin_out_t pin_out;
  assign pin_in = {pin_out.sck_oe & pin_out.sck_o,
                   pin_out.mosi_oe & pin_out.mosi_o, miso, ss_n};
  spf_spi_flags spf_spi_flags_i (.clock(clock), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .vector_ack(vector_ack), .pin_in(pin_in), .pin_out(pin_out),
    .busy(busy));
  spf_slave_model spf_slave_model_i (.sck(pin_in.sck), .mosi(pin_in.mosi),
    .sel_n(sel_n), .miso(miso), .rx_hist(rx_hist));
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // read and write strobes always get one idle cycle after them
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
    @(posedge clock);
  endtask
  task automatic rd_reg(input logic [2:0] a);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1 v = rdata;
    @(posedge clock);
  endtask
  task automatic wait_idle();
    repeat (2) @(posedge clock);
    for (int i = 0; i < 300 && busy !== 1'h0; i++) @(posedge clock);
    check("busy", busy, 16'h0000);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    reset_n = 1'h0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    vector_ack = 1'h0;
    ss_n = 1'h1;
    sel_n = 1'h0;
    repeat (10) @(posedge clock);
    reset_n <= 1'h1;
    @(posedge clock);
    rd_reg(spf_pkg::OFF_FLAG);
    check("flags", v, 16'h0000);
    rd_reg(3'h1);
    check("unmapped", v, 16'h0000);
    wr_reg(spf_pkg::OFF_CTRL, 8'h21);
    wr_reg(spf_pkg::OFF_DATA, 8'h5A);
    wr_reg(spf_pkg::OFF_DATA, 8'h77);
    wait_idle();
    check("sent", rx_hist[7:0], 16'h005A);
    rd_reg(spf_pkg::OFF_FLAG);
    check("flags", v, 16'h00C0);
    rd_reg(spf_pkg::OFF_DATA);
    check("data", v, 16'h00A0);
    rd_reg(spf_pkg::OFF_FLAG);
    check("flags", v, 16'h0000);
    wr_reg(spf_pkg::OFF_DATA, 8'h96);
    wait_idle();
    check("sent", rx_hist, 16'h5A96);
    vector_ack <= 1'h1;
    @(posedge clock);
    vector_ack <= 1'h0;
    rd_reg(spf_pkg::OFF_FLAG);
    check("flags", v, 16'h0000);
    // second reset in mid-run leaves buffers empty for buffered mode
    reset_n <= 1'h0;
    @(posedge clock);
    reset_n <= 1'h1;
    @(posedge clock);
    wr_reg(spf_pkg::OFF_CTRL, 8'hA1);
    wr_reg(spf_pkg::OFF_DATA, 8'h11);
    wr_reg(spf_pkg::OFF_DATA, 8'h22);
    rd_reg(spf_pkg::OFF_FLAG);
    check("empty", v & 8'h20, 16'h0000);
    wait_idle();
    wait_idle();
    check("sent", rx_hist, 16'h1122);
    rd_reg(spf_pkg::OFF_FLAG);
    check("flags", v, 16'h00E0);
    wr_reg(spf_pkg::OFF_FLAG, 8'h40);
    rd_reg(spf_pkg::OFF_FLAG);
    check("flags", v, 16'h00A0);
    wr_reg(spf_pkg::OFF_DATA, 8'h33);
    wait_idle();
    rd_reg(spf_pkg::OFF_FLAG);
    check("flags", v, 16'h00E0);
    wr_reg(spf_pkg::OFF_DATA, 8'h44);
    repeat (4) @(posedge clock);
    rd_reg(spf_pkg::OFF_FLAG);
    check("flags", v, 16'h00E1);
    rd_reg(spf_pkg::OFF_DATA);
    check("data", v, 16'h00A2);
    rd_reg(spf_pkg::OFF_FLAG);
    check("overflow", v & 8'h01, 16'h0000);
    wait_idle();
    rd_reg(spf_pkg::OFF_DATA);
    check("data", v, 16'h00A3);
    rd_reg(spf_pkg::OFF_DATA);
    check("data", v, 16'h00A5);
    rd_reg(spf_pkg::OFF_FLAG);
    check("rx done", v & 8'h80, 16'h0000);
    wr_reg(spf_pkg::OFF_CTRL, 8'hA5);
    ss_n <= 1'h0;
    repeat (8) @(posedge clock);
    rd_reg(spf_pkg::OFF_FLAG);
    check("select", v & 8'h10, 16'h0000);
    ss_n <= 1'h1;
    repeat (8) @(posedge clock);
    wr_reg(spf_pkg::OFF_CTRL, 8'hA1);
    ss_n <= 1'h0;
    repeat (8) @(posedge clock);
    rd_reg(spf_pkg::OFF_FLAG);
    check("select", v & 8'h10, 16'h0010);
    rd_reg(spf_pkg::OFF_CTRL);
    check("ctrl", v, 16'h0081);
    check("drive", {pin_out.sck_oe, pin_out.miso_oe}, 16'h0001);
    wr_reg(spf_pkg::OFF_FLAG, 8'h10);
    rd_reg(spf_pkg::OFF_FLAG);
    check("select", v & 8'h10, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
